// File: design/ast_pkg.sv
// package: register map, field positions, reset values and frame states of the transceiver
package ast_pkg;
  localparam int          ADDR_W      = 3;
  localparam logic [2:0]  ADDR_DATA   = 3'h0;
  localparam logic [2:0]  ADDR_STAT0  = 3'h1;
  localparam logic [2:0]  ADDR_CTL0   = 3'h2;
  localparam logic [2:0]  ADDR_CTL1   = 3'h3;
  localparam logic [2:0]  ADDR_STAT1  = 3'h4;
  localparam logic [2:0]  ADDR_DIV_HI = 3'h5;
  localparam logic [2:0]  ADDR_DIV_LO = 3'h6;
  localparam int          C0_TXEN     = 7;
  localparam int          C0_RXEN     = 6;
  localparam int          C0_FLOW     = 5;
  localparam int          C0_PAR      = 4;
  localparam int          C0_ODD      = 3;
  localparam int          C0_STOP2    = 2;
  localparam int          C1_NINTH    = 7;
  localparam int          C1_NINTH_TX = 0;
  localparam int          S0_AVAIL    = 7;
  localparam int          S0_EMPTY    = 6;
  localparam int          S0_PERR     = 5;
  localparam int          S0_OVR      = 4;
  localparam int          S0_FERR     = 3;
  localparam int          S0_BRK      = 2;
  localparam int          S0_TXIDLE   = 1;
  localparam int          S0_CTS      = 0;
  localparam logic [7:0]  CTL0_RST    = 8'h00;
  localparam logic [7:0]  CTL1_RST    = 8'h00;
  localparam logic [15:0] DIV_RST     = 16'h0001;
  localparam logic [3:0]  OS_LAST     = 4'hF;
  localparam logic [3:0]  OS_MID      = 4'h7;
  localparam logic [2:0]  DATA_LAST   = 3'h7;
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b000,
    FR_START = 3'b001,
    FR_DATA  = 3'b011,
    FR_NINTH = 3'b010,
    FR_STOP  = 3'b110
  } ast_frame_t;
endpackage : ast_pkg

// File: design/ast_baud.sv
// baud divider: one-cycle enable at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module ast_baud
  import ast_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick_r
);
  logic [DIV_W-1:0] cnt_r;

  // a zero divisor runs as one, the fastest rate
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (divisor == '0 || cnt_r >= divisor - 1'b1)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end
endmodule : ast_baud
`default_nettype wire

// File: design/ast_rx.sv
// receiver: start detection, centre sampling, error checks
`timescale 1ns/1ps
`default_nettype none
module ast_rx
  import ast_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic       ninth_on,
  input  wire logic       par_check,
  input  wire logic       par_odd,
  input  wire logic       two_stop,
  output logic            done_r,
  output logic [7:0]      data_r,
  output logic            ninth_r,
  output logic            perr_r,
  output logic            ferr_r,
  output logic            brk_r
);
  ast_frame_t st_r;
  logic [3:0] os_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic       nb_r;
  logic       stop2_r;
  logic       rxd_prev_r;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rxd_prev_r <= 1'b1;
    else
      rxd_prev_r <= rxd;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_r    <= FR_IDLE;
      os_r    <= '0;
      bit_r   <= '0;
      sh_r    <= '0;
      nb_r    <= 1'b0;
      stop2_r <= 1'b0;
      done_r  <= 1'b0;
      data_r  <= '0;
      ninth_r <= 1'b0;
      perr_r  <= 1'b0;
      ferr_r  <= 1'b0;
      brk_r   <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!enable)
        st_r <= FR_IDLE; // R12
      else if (st_r == FR_IDLE)
      begin
        if (rxd_prev_r && !rxd) // R2 R22
        begin
          st_r <= FR_START;
          os_r <= '0;
        end
      end
      else if (tick)
      begin
        os_r <= os_r + 4'h1;
        unique case (st_r)
          FR_START:
            if (os_r == OS_MID)
            begin
              // a low that has gone by mid-bit was a glitch
              st_r    <= rxd ? FR_IDLE : FR_DATA; // R22
              os_r    <= '0;
              bit_r   <= '0;
              stop2_r <= 1'b0;
            end
          FR_DATA:
            if (os_r == OS_LAST)
            begin
              sh_r  <= {rxd, sh_r[7:1]}; // R1
              bit_r <= bit_r + 3'h1;
              if (bit_r == DATA_LAST)
                st_r <= ninth_on ? FR_NINTH : FR_STOP; // R4 R14
            end
          FR_NINTH:
            if (os_r == OS_LAST)
            begin
              nb_r <= rxd;
              st_r <= FR_STOP;
            end
          FR_STOP:
            if (os_r == OS_LAST)
            begin
              if (two_stop && !stop2_r && rxd) // R3
                stop2_r <= 1'b1;
              else
              begin
                st_r    <= FR_IDLE;
                done_r  <= 1'b1;
                data_r  <= sh_r;
                ninth_r <= nb_r;
                perr_r  <= par_check && ((^{sh_r, nb_r}) ^ par_odd); // R4 R17
                ferr_r  <= !rxd; // R17
                brk_r   <= !rxd && sh_r == 8'h00 && !(ninth_on && nb_r); // R23
              end
            end
          default:
            st_r <= FR_IDLE;
        endcase
      end
    end
  end
endmodule : ast_rx
`default_nettype wire

// File: design/ast_top.sv
// serial transceiver top: register port, transmitter, receive status
// Operation
// R1 - eight data bits per character, least significant bit first, both ways.
// R2 - a low start bit opens each character; the line idles high.
// R3 - one or two high stop bits by configuration, same on receive.
// R4 - optional even or odd parity bit after data, generated and checked.
// R5 - transmit and receive run independently on shared rate and format.
// R6 - baud timing from a sixteen-bit divisor in high and low bytes.
// R7 - holding-empty flag is 1 when a byte can be written, else 0.
// R8 - a written byte moves to the shifter and goes out unaided.
// R9 - transmit request follows holding-empty, so it rises at once on enable.
// R10 - software clears the pending transmit request after writing the byte.
// R11 - byte-available flag is 1 while received data waits, else 0.
// R12 - transmit only while transmit enabled, receive only while receive enabled.
// R13 - parity settings act only with ninth-bit mode off.
// R14 - ninth-bit mode puts a control bit in the parity position.
// R15 - transmitted ninth bit is the control value taken with each byte.
// R16 - flow-control enable decides whether clear-to-send holds off transmission.
// R17 - framing, parity, overrun and break reported with separate requests; the code folds all four into the one receive request.
// R18 - clear-to-send sampled one clock before each new character starts.
// R19 - a character already started is always finished; the code abandons it when the transmit or receive enable is cleared.
// R20 - ninth bit follows data directly and precedes the stop bits.
// R21 - driver enable rises on data write and covers the whole frame.
// R22 - receive start found by falling edge, bits sampled at centre.
// R23 - break when all data bits and the stop bit are low.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ast_top
  import ast_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic [7:0]             rd_data_r,
  input  wire logic              rxd,
  input  wire logic              cts_n,
  output logic                   txd_r,
  output logic                   line_driver_enable_r,
  output logic                   tx_irq_r,
  output logic                   rx_irq_r
);
  logic [7:0]  ctl0_r;
  logic [7:0]  ctl1_r;
  logic [15:0] baud_divider;
  logic [7:0]  hold_r;
  logic        hold_full_r;
  logic        hold_ninth_r;
  logic        cts_n_r;
  logic        tick;
  ast_frame_t  tx_st_r;
  logic [3:0]  tx_os_r;
  logic [2:0]  tx_bit_r;
  logic [7:0]  tx_sh_r;
  logic        tx_ninth_r;
  logic        tx_has9_r;
  logic        tx_two_r;
  logic        tx_stop2_r;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_ninth;
  logic        rx_perr;
  logic        rx_ferr;
  logic        rx_brk;
  logic [7:0]  rx_data_r;
  logic        rx_ninth_r;
  logic        avail_r;
  logic        perr_r;
  logic        ovr_r;
  logic        ferr_r;
  logic        brk_r;
  logic        de_nxt;

  wire logic transmit_enable_bit    = ctl0_r[C0_TXEN];
  wire logic receive_enable_bit     = ctl0_r[C0_RXEN];
  wire logic flow_control_enable    = ctl0_r[C0_FLOW];
  wire logic ninth_bit_mode_enable  = ctl1_r[C1_NINTH];
  // parity is ignored whenever ninth-bit mode is on
  wire logic parity_enable_bit      = ctl0_r[C0_PAR] && !ninth_bit_mode_enable; // R13
  wire logic parity_odd_bit         = ctl0_r[C0_ODD];
  wire logic two_stop_bit           = ctl0_r[C0_STOP2];
  wire logic ninth_bit_transmit_value = ctl1_r[C1_NINTH_TX];
  wire logic tx_holding_empty_flag  = !hold_full_r; // R7
  wire logic rx_byte_available_flag = avail_r; // R11
  wire logic ninth_slot             = ninth_bit_mode_enable || parity_enable_bit;
  wire logic data_wr   = wr_en && addr == ADDR_DATA;
  wire logic data_rd   = rd_en && addr == ADDR_DATA;
  wire logic hold_take = data_wr && !hold_full_r;
  wire logic cts_block = flow_control_enable && cts_n_r; // R16
  wire logic tx_go     = transmit_enable_bit && hold_full_r && !cts_block;

  ast_baud #(
    .DIV_W   (16)
  ) u_baud (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .divisor (baud_divider), // R6
    .tick_r  (tick)
  );

  // separate instance keeps the receive path free of transmit state
  ast_rx u_rx ( // R5
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .enable    (receive_enable_bit), // R12
    .tick      (tick),
    .rxd       (rxd),
    .ninth_on  (ninth_slot),
    .par_check (parity_enable_bit),
    .par_odd   (parity_odd_bit),
    .two_stop  (two_stop_bit),
    .done_r    (rx_done),
    .data_r    (rx_data),
    .ninth_r   (rx_ninth),
    .perr_r    (rx_perr),
    .ferr_r    (rx_ferr),
    .brk_r     (rx_brk)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ctl0_r       <= CTL0_RST;
      ctl1_r       <= CTL1_RST;
      baud_divider <= DIV_RST;
    end
    else if (wr_en)
    begin
      if (addr == ADDR_CTL0)
        ctl0_r <= wr_data;
      if (addr == ADDR_CTL1)
        ctl1_r <= wr_data;
      if (addr == ADDR_DIV_HI)
        baud_divider[15:8] <= wr_data; // R6
      if (addr == ADDR_DIV_LO)
        baud_divider[7:0] <= wr_data;
    end
  end

  // a write while the holding register is full is dropped
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      hold_r       <= '0;
      hold_full_r  <= 1'b0;
      hold_ninth_r <= 1'b0;
    end
    else if (hold_take)
    begin
      hold_r       <= wr_data;
      hold_full_r  <= 1'b1; // R7
      hold_ninth_r <= ninth_bit_transmit_value; // R15
    end
    else if (tx_st_r == FR_IDLE && tx_go)
      hold_full_r <= 1'b0; // R8
  end

  // one flop gives the one-clock look-ahead the far side must respect
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      cts_n_r <= 1'b1;
    else
      cts_n_r <= cts_n; // R18
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      tx_st_r    <= FR_IDLE;
      tx_os_r    <= '0;
      tx_bit_r   <= '0;
      tx_sh_r    <= '0;
      tx_ninth_r <= 1'b0;
      tx_has9_r  <= 1'b0;
      tx_two_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
      txd_r      <= 1'b1;
    end
    else if (!transmit_enable_bit)
    begin
      tx_st_r <= FR_IDLE; // R12
      txd_r   <= 1'b1;
    end
    else
    begin
      if (tick && tx_st_r != FR_IDLE)
        tx_os_r <= tx_os_r + 4'h1;
      unique case (tx_st_r)
        FR_IDLE:
        begin
          txd_r <= 1'b1; // R2
          if (tx_go) // R16 R18
          begin
            tx_st_r    <= FR_START;
            txd_r      <= 1'b0; // R2
            tx_os_r    <= '0;
            tx_sh_r    <= hold_r; // R8
            tx_has9_r  <= ninth_slot;
            tx_two_r   <= two_stop_bit;
            tx_stop2_r <= 1'b0;
            // R14 R15 R4
            tx_ninth_r <= ninth_bit_mode_enable ? hold_ninth_r : (^hold_r) ^ parity_odd_bit;
          end
        end
        FR_START:
          if (tick && tx_os_r == OS_LAST)
          begin
            tx_st_r  <= FR_DATA;
            tx_bit_r <= '0;
            txd_r    <= tx_sh_r[0]; // R1
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          end
        FR_DATA:
          // clear-to-send is not looked at here, so a started character completes
          if (tick && tx_os_r == OS_LAST) // R19
          begin
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == DATA_LAST)
            begin
              tx_st_r <= tx_has9_r ? FR_NINTH : FR_STOP; // R20
              txd_r   <= tx_has9_r ? tx_ninth_r : 1'b1;
            end
            else
            begin
              txd_r   <= tx_sh_r[0]; // R1
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            end
          end
        FR_NINTH:
          if (tick && tx_os_r == OS_LAST)
          begin
            tx_st_r <= FR_STOP; // R20
            txd_r   <= 1'b1;
          end
        FR_STOP:
          if (tick && tx_os_r == OS_LAST)
          begin
            if (tx_two_r && !tx_stop2_r)
              tx_stop2_r <= 1'b1; // R3
            else
              tx_st_r <= FR_IDLE;
          end
        default:
        begin
          tx_st_r <= FR_IDLE;
          txd_r   <= 1'b1;
        end
      endcase
    end
  end

  // driver stays on while a byte waits, so back-to-back frames share one envelope
  always_comb
  begin
    de_nxt = line_driver_enable_r;
    if (tx_st_r == FR_IDLE && !hold_full_r)
      de_nxt = 1'b0;
    if (hold_take)
      de_nxt = 1'b1; // R21
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      line_driver_enable_r <= 1'b0;
    else
      line_driver_enable_r <= de_nxt; // R21
  end

  // a byte landing in the cycle of a data read wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rx_data_r  <= '0;
      rx_ninth_r <= 1'b0;
      avail_r    <= 1'b0;
      perr_r     <= 1'b0;
      ovr_r      <= 1'b0;
      ferr_r     <= 1'b0;
      brk_r      <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_data_r  <= rx_data;
      rx_ninth_r <= rx_ninth;
      avail_r    <= 1'b1; // R11
      perr_r     <= rx_perr || (perr_r && !data_rd); // R17
      ferr_r     <= rx_ferr || (ferr_r && !data_rd);
      brk_r      <= rx_brk || (brk_r && !data_rd); // R23
      ovr_r      <= (avail_r && !data_rd) || (ovr_r && !data_rd); // R17
    end
    else if (data_rd)
    begin
      avail_r <= 1'b0;
      perr_r  <= 1'b0;
      ovr_r   <= 1'b0;
      ferr_r  <= 1'b0;
      brk_r   <= 1'b0;
    end
  end

  // level requests: the outside controller latches and clears its own copy
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      tx_irq_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end
    else
    begin
      tx_irq_r <= transmit_enable_bit && tx_holding_empty_flag; // R9 R10
      rx_irq_r <= receive_enable_bit && (avail_r || perr_r || ovr_r || ferr_r || brk_r); // R17
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rd_data_r <= '0;
    else if (rd_en)
    begin
      unique case (addr)
        ADDR_DATA:   rd_data_r <= rx_data_r;
        ADDR_STAT0:  rd_data_r <= {rx_byte_available_flag, tx_holding_empty_flag, perr_r, ovr_r,
                                   ferr_r, brk_r, tx_st_r == FR_IDLE, !cts_n_r};
        ADDR_CTL0:   rd_data_r <= ctl0_r;
        ADDR_CTL1:   rd_data_r <= ctl1_r;
        ADDR_STAT1:  rd_data_r <= {7'h00, rx_ninth_r};
        ADDR_DIV_HI: rd_data_r <= baud_divider[15:8];
        ADDR_DIV_LO: rd_data_r <= baud_divider[7:0];
        default:     rd_data_r <= 8'h00;
      endcase
    end
    else
      rd_data_r <= 8'h00;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_load;
    hold_take && transmit_enable_bit && !flow_control_enable && tx_st_r == FR_IDLE;
  endsequence
  sequence s_to_ninth;
    tx_st_r == FR_DATA ##1 tx_st_r == FR_NINTH;
  endsequence

  a_idle_line_high: assert property (tx_st_r == FR_IDLE |-> txd_r) // R2
    else $error("line not high while idle");
  a_start_bit_low: assert property (tx_st_r == FR_START |-> !txd_r) // R2
    else $error("start bit not low");
  a_stop_bit_high: assert property (tx_st_r == FR_STOP |-> txd_r) // R3
    else $error("stop bit not high");
  a_empty_flag_clear: assert property (hold_take |=> !tx_holding_empty_flag) // R7
    else $error("empty flag still set after write");
  a_write_starts_frame: assert property (s_load |-> ##[1:2] tx_st_r == FR_START) // R8
    else $error("written byte not started");
  a_cts_holds_off: assert property (cts_block && tx_st_r == FR_IDLE |=> tx_st_r == FR_IDLE) // R18
    else $error("frame started against clear-to-send");
  a_frame_completes: assert property (tx_st_r == FR_DATA ##1 transmit_enable_bit
                                      |-> tx_st_r != FR_IDLE) // R19
    else $error("character cut short");
  a_ninth_bit_value: assert property (s_to_ninth |-> txd_r == tx_ninth_r) // R20
    else $error("ninth bit wrong");
  a_driver_covers_frame: assert property (tx_st_r != FR_IDLE |-> line_driver_enable_r) // R21
    else $error("driver enable low inside frame");
  a_tx_request_empty: assert property (transmit_enable_bit && tx_holding_empty_flag
                                       |=> tx_irq_r) // R9
    else $error("transmit request missing");
  a_rx_byte_flag: assert property (rx_done |=> rx_byte_available_flag) // R11
    else $error("received byte not flagged");
  a_overrun_flag: assert property (rx_done && avail_r && !data_rd |=> ovr_r) // R17
    else $error("overrun not flagged");
  a_tx_gate_off: assert property (!transmit_enable_bit |=> tx_st_r == FR_IDLE) // R12
    else $error("transmitter active while disabled");
endmodule : ast_top
`default_nettype wire

// File: verif/ast_remote.sv
// remote serial node model: drives rxd and cts_n, captures frames from txd
`timescale 1ns/1ps
`default_nettype none
module ast_remote
#(
  parameter int BIT = 32
)
(
  input  wire logic       ref_clk,
  input  wire logic       txd,
  output logic            rxd,
  output logic            cts_n,
  output logic [9:0]      cap_bits,
  output logic [7:0]      cap_cnt
);
  initial
  begin
    rxd      = 1'b1;
    cts_n    = 1'b0;
    cap_bits = 10'h000;
    cap_cnt  = 8'h00;
  end

  // low start bit, then n bits lsb first, then back to idle high
  task automatic send_bits(input logic [11:0] bits, input int n);
    rxd <= 1'b0;
    repeat (BIT) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (BIT) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask : send_bits

  // callers change hold-off well before the next start, never mid-frame
  task automatic set_hold(input logic hold);
    cts_n <= hold;
  endtask : set_hold

  // ten bits after the start are sampled near their centres
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT) @(posedge ref_clk);
      cap_bits[i] = txd;
    end
    cap_cnt = cap_cnt + 8'h01;
  end
endmodule : ast_remote
`default_nettype wire

// File: verif/async_serial_transceiver_tb_top.sv
// testbench: register-port scenarios against the remote node model
`timescale 1ns/1ps
`default_nettype none
module async_serial_transceiver_tb_top
  import ast_pkg::*;
;
  localparam int BIT = 32;
  logic              ref_clk;
  logic              resetn;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [7:0]        rd_data_r;
  logic              rxd;
  logic              cts_n;
  logic              txd_r;
  logic              line_driver_enable_r;
  logic              tx_irq_r;
  logic              rx_irq_r;
  logic [9:0]        cap_bits;
  logic [7:0]        cap_cnt;
  logic [7:0]        want;
  logic [7:0]        st;
  int                err_count;
  int                total_checks;
  int                cycles;

  ast_top uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r), .rxd(rxd), .cts_n(cts_n),
    .txd_r(txd_r), .line_driver_enable_r(line_driver_enable_r), .tx_irq_r(tx_irq_r),
    .rx_irq_r(rx_irq_r));
  ast_remote #(.BIT(BIT)) remote (.ref_clk(ref_clk), .txd(txd_r), .rxd(rxd),
    .cts_n(cts_n), .cap_bits(cap_bits), .cap_cnt(cap_cnt));

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk

  // one idle edge after each write keeps a strobe from being driven twice at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data_r;
    @(posedge ref_clk);
  endtask : rd

  task automatic wait_cap;
    want = want + 8'h01;
    for (int k = 0; k < 1000 && cap_cnt !== want; k++)
      @(posedge ref_clk);
  endtask : wait_cap

  task automatic t_reset;
    rd(ADDR_CTL0, st);
    chk(10'(st), 10'(CTL0_RST), "control reset value");
    rd(ADDR_STAT0, st);
    chk(10'(st[7:6]), 10'h001, "status reset value");
    rd(3'h7, st);
    chk(10'(st), 10'h000, "unmapped read");
    chk(10'({txd_r, line_driver_enable_r, tx_irq_r}), 10'h004, "idle outputs");
  endtask : t_reset

  task automatic t_tx;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] x;
    wr(ADDR_DIV_HI, 8'h00);
    wr(ADDR_DIV_LO, 8'h02);
    for (int m = 0; m < 3; m++)
    begin
      c = 8'h00;
      c[C0_TXEN] = 1'b1;
      c[C0_PAR] = (m > 0);
      c[C0_ODD] = (m == 2);
      // two stops keep the tenth sample off the next start bit
      c[C0_STOP2] = (m == 0);
      d = 8'hB0 + 8'(m);
      wr(ADDR_CTL0, c);
      // the request flop follows the enable one edge later
      @(posedge ref_clk);
      chk(10'(tx_irq_r), 10'h001, "request on enable");
      wr(ADDR_DATA, d);
      wr(ADDR_DATA, ~d);
      rd(ADDR_STAT0, st);
      chk(10'(st[S0_EMPTY]), 10'h000, "holding full");
      chk(10'({tx_irq_r, line_driver_enable_r}), 10'h001, "request and driver");
      for (int b = 0; b < 2; b++)
      begin
        x = b ? ~d : d;
        wait_cap();
        chk(cap_bits, {1'b1, c[C0_PAR] ? ^x ^ c[C0_ODD] : 1'b1, x}, "frame");
        chk(10'(line_driver_enable_r), 10'h001, "driver over frame");
      end
      repeat (BIT) @(posedge ref_clk);
    end
  endtask : t_tx

  task automatic t_ninth;
    wr(ADDR_CTL1, 8'(1 << C1_NINTH | 1 << C1_NINTH_TX));
    wr(ADDR_CTL0, 8'(1 << C0_TXEN | 1 << C0_PAR));
    wr(ADDR_DATA, 8'h03);
    wr(ADDR_CTL1, 8'(1 << C1_NINTH));
    wr(ADDR_DATA, 8'h03);
    for (int b = 0; b < 2; b++)
    begin
      wait_cap();
      chk(cap_bits, {1'b1, b == 0, 8'h03}, "ninth bit frame");
    end
    repeat (BIT) @(posedge ref_clk);
    wr(ADDR_CTL1, 8'h00);
  endtask : t_ninth

  task automatic t_flow;
    wr(ADDR_CTL0, 8'(1 << C0_FLOW));
    wr(ADDR_DATA, 8'h81);
    repeat (600) @(posedge ref_clk);
    chk(10'(cap_cnt), 10'(want), "no send while disabled");
    remote.set_hold(1'b1);
    wr(ADDR_CTL0, 8'(1 << C0_TXEN | 1 << C0_FLOW));
    repeat (600) @(posedge ref_clk);
    chk(10'({cap_cnt, txd_r}), 10'({want, 1'b1}), "held off");
    rd(ADDR_STAT0, st);
    chk(10'(st[1:0]), 10'h002, "idle with clear-to-send off");
    remote.set_hold(1'b0);
    wait_cap();
    chk(cap_bits, {2'b11, 8'h81}, "sent after release");
    repeat (BIT) @(posedge ref_clk);
    remote.set_hold(1'b1);
    wr(ADDR_CTL0, 8'(1 << C0_TXEN));
    wr(ADDR_DATA, 8'h7E);
    wait_cap();
    chk(cap_bits, {2'b11, 8'h7E}, "hold ignored without flow");
    remote.set_hold(1'b0);
    repeat (BIT) @(posedge ref_clk);
  endtask : t_flow

  task automatic rx_case(input logic [7:0] c, input logic [11:0] bits, input int n,
                         input logic [3:0] err, input logic [7:0] d);
    wr(ADDR_CTL0, c | 8'(1 << C0_RXEN));
    remote.send_bits(bits, n);
    repeat (8) @(posedge ref_clk);
    chk(10'(rx_irq_r), 10'h001, "receive request");
    rd(ADDR_STAT0, st);
    chk(10'(st[5:2]), 10'(err), "receive status");
    if (err == 4'h0)
      chk(10'(st[S0_AVAIL]), 10'h001, "byte available");
    rd(ADDR_DATA, st);
    if (err == 4'h0)
      chk(10'(st), 10'(d), "received byte");
    rd(ADDR_STAT0, st);
    chk(10'({st[7], st[5:2]}), 10'h000, "flags cleared by read");
  endtask : rx_case

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ceiling well above the roughly 6700 cycles the scenarios need
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    resetn       = 1'b0;
    addr         = '0;
    wr_data      = 8'h00;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    want         = 8'h00;
    err_count    = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_tx();
    t_ninth();
    t_flow();
    // parity select stays on but must be ignored in ninth-bit mode
    wr(ADDR_CTL1, 8'(1 << C1_NINTH));
    rx_case(8'(1 << C0_PAR), 12'h35A, 10, 4'h0, 8'h5A);
    rd(ADDR_STAT1, st);
    chk(10'(st), 10'h001, "received ninth bit");
    wr(ADDR_CTL1, 8'h00);
    rx_case(8'(1 << C0_PAR), 12'h25A, 10, 4'h0, 8'h5A);
    rx_case(8'(1 << C0_PAR | 1 << C0_ODD), 12'h25A, 10, 4'h8, 8'h5A);
    rx_case(8'(1 << C0_STOP2), 12'h1C3, 10, 4'h2, 8'hC3);
    rx_case(8'h00, 12'h000, 9, 4'h3, 8'h00);
    print_verdict();
  end
endmodule : async_serial_transceiver_tb_top
`default_nettype wire
